// file: core/tmv_pkg.sv
// Purpose: shared constants for the compare-match timer status/output/trigger block
// Assumes: 32-bit axi4-lite register bus, one word per register
// Notes: byte offsets below are the register addresses
package tmv_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_CMP_A = 8'h04;
  localparam logic [7:0] OFS_CMP_B = 8'h08;
  localparam logic [7:0] OFS_MAIN_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS_OUT = 8'h10;
  localparam logic [7:0] OFS_TRIG_CTRL = 8'h14;
  // ---------------------------------------------------------------
  // field positions, status/output select register
  // ---------------------------------------------------------------
  localparam int POS_FLAG_B = 7;
  localparam int POS_FLAG_A = 6;
  localparam int POS_WRAP = 5;
  localparam int POS_ACT_B = 2;
  localparam int POS_ACT_A = 0;
  // trigger control register
  localparam int POS_EDGE = 3;
  localparam int POS_GATE = 2;
  localparam int POS_XCKS = 0;
  // main control register
  localparam int POS_IE_B = 7;
  localparam int POS_IE_A = 6;
  localparam int POS_IE_WRAP = 5;
  localparam int POS_CLR = 3;
  localparam int POS_CKS = 0;
  // ---------------------------------------------------------------
  // reserved read-one masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RSVD_ONES = 8'h10;
  localparam logic [7:0] TRIG_RSVD_ONES = 8'he2;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmv_pkg

// file: core/tmv_ctl_if.sv
// Purpose: control bundle from register file to timer core
// Assumes: single clock domain
// Notes: regs drives the control fields, core drives count, match_a, match_b and wrap
`timescale 1ns/1ns
`default_nettype none
interface tmv_ctl_if;
  logic [1:0] clk_sel_lo2; // clock select low two bits
  logic clk_sel_hi; // clock select high bit
  logic xcks; // extra internal clock select
  logic [1:0] clr_sel; // counter clear select
  logic [1:0] edge_sel; // trigger edge select
  logic gate_en; // trigger gating enable
  logic cnt_wr; // software write to counter
  logic [7:0] cnt_wdata; // counter write data
  logic [7:0] count; // counter value
  logic match_a; // compare match a pulse
  logic match_b; // compare match b pulse
  logic wrap; // wrap pulse
  logic [7:0] cmp_a; // compare value a
  logic [7:0] cmp_b; // compare value b
  modport regs (output clk_sel_lo2, clk_sel_hi, xcks, clr_sel, edge_sel, gate_en, cnt_wr, cnt_wdata, cmp_a, cmp_b,
                input count, match_a, match_b, wrap);
  modport core (input clk_sel_lo2, clk_sel_hi, xcks, clr_sel, edge_sel, gate_en, cnt_wr, cnt_wdata, cmp_a, cmp_b,
                output count, match_a, match_b, wrap);
endinterface : tmv_ctl_if
`default_nettype wire

// file: core/tmv_prescale.sv
// Purpose: internal prescaler, one-cycle count enable
// Assumes: divisions 4 to 128 of aclk
// Notes: select change may produce a stray tick, as on the original counter
`timescale 1ns/1ns
`default_nettype none
module tmv_prescale (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [1:0] sel, // internal division pair select
  input wire logic xcks, // extra select bit
  output logic tick // one-cycle count enable
);
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic [2:0] tap;
  logic tap_prev_reg;
  logic tap_now;
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  assign div_next = div_reg + 7'h01;
  // adjacent division pick
  // stopped select parks on bit 0 so the tap never indexes past the divider
  assign tap = (sel == 2'h0) ? 3'h0 : {sel - 2'h1, xcks} + 3'h1;
  assign tap_now = div_reg[tap];
  // falling tap edge gives the tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg <= 7'h00;
      tap_prev_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tap_prev_reg <= tap_now;
    end
  end
  assign tick = tap_prev_reg & ~tap_now & (sel != 2'h0);
endmodule : tmv_prescale
`default_nettype wire

// file: core/tmv_counter.sv
// Purpose: 8-bit up-counter with compare, clear and trigger start/halt
// Assumes: trigger and clear pins synchronous to aclk
// Notes: external clock input is not modelled; those selects do not count
`timescale 1ns/1ns
`default_nettype none
module tmv_counter (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic trig_in, // trigger input level
  input wire logic ext_clr_in, // external clear input level
  tmv_ctl_if.core ctl // control bundle
);
  logic [7:0] cnt_reg;
  logic run_reg;
  logic trig_prev_reg;
  logic clr_prev_reg;
  logic tick;
  logic inc;
  logic trig_edge;
  logic ext_rise;
  logic clr_hit;
  logic [7:0] cnt_next;
  tmv_prescale u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(ctl.clk_sel_lo2),
    .xcks(ctl.xcks),
    .tick(tick)
  );
  // ---------------------------------------------------------------
  // edge detection and clear decode
  // ---------------------------------------------------------------
  // trigger edge decode
  assign trig_edge = (ctl.edge_sel[0] & trig_in & ~trig_prev_reg) |
                     (ctl.edge_sel[1] & ~trig_in & trig_prev_reg);
  assign ext_rise = ext_clr_in & ~clr_prev_reg;
  assign inc = tick & ~ctl.clk_sel_hi & run_reg;
  assign ctl.match_a = inc & (cnt_reg == ctl.cmp_a);
  assign ctl.match_b = inc & (cnt_reg == ctl.cmp_b);
  assign ctl.wrap = inc & (cnt_reg == tmv_pkg::COUNT_MAX);
  assign clr_hit = (ctl.clr_sel == tmv_pkg::CLR_MATCH_A && ctl.match_a) ||
                   (ctl.clr_sel == tmv_pkg::CLR_MATCH_B && ctl.match_b) ||
                   (ctl.clr_sel == tmv_pkg::CLR_EXT && ext_rise);
  assign cnt_next = clr_hit ? tmv_pkg::RST_COUNT :
                    ctl.cnt_wr ? ctl.cnt_wdata :
                    inc ? cnt_reg + 8'h01 : cnt_reg;
  assign ctl.count = cnt_reg;
  // counter and run state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= tmv_pkg::RST_COUNT;
      run_reg <= 1'b1;
      trig_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      trig_prev_reg <= trig_in;
      clr_prev_reg <= ext_clr_in;
      if (!ctl.gate_en)
        run_reg <= 1'b1;
      else if (clr_hit)
        run_reg <= 1'b0;
      else if (trig_edge)
        run_reg <= 1'b1;
    end
  end
endmodule : tmv_counter
`default_nettype wire

// file: core/tmv_top.sv
// Purpose: 8-bit compare-match timer, status flags, output select, trigger control
// Assumes: axi4-lite slave, 32-bit data, one access of each kind at a time
// Notes: reads answer one cycle after address; writes two cycles after both halves
// Notes on behaviour
// - flag b sets when the counter equals compare value b
// - flag a sets when the counter equals compare value a
// - wrap flag sets when the counter goes from ff to 00
// - a flag clears on writing 0 only after it was read as 1
// - reserved status bit 4 and trigger bits 7-5,1 read 1
// - match b drives pin per 2-bit action: keep, 0, 1, toggle
// - match a drives pin per its own 2-bit action, same code
// - the two match actions are set independently
// - after reset the waveform pin is 0 until a match
// - edge select: off, rising, falling, both
// - gating on: clear halts counting, selected trigger edge restarts
// - gating off: trigger ignored, match clear does not halt
// - extra select bit picks between adjacent prescaler divisions
// - 8-bit up-counter, software read/write anytime, resets to zero
// - clear select: never, match a, match b, external rising edge
// - interrupt request when a flag and its enable are both 1
// - simultaneous matches: toggle over 1 over 0
`timescale 1ns/1ns
`default_nettype none
module tmv_top (
  input wire logic aclk, // system clock, 250 mhz
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic trigger_in_pin, // trigger input
  input wire logic external_clear_pin, // external counter clear
  output logic waveform_out_pin, // waveform output
  output logic irq // interrupt request, level
);
  tmv_ctl_if ctl ();
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] main_ctrl_reg;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic flag_b_reg;
  logic flag_a_reg;
  logic wrap_flag_reg;
  logic [1:0] act_b_reg;
  logic [1:0] act_a_reg;
  logic [1:0] edge_reg;
  logic gate_reg;
  logic xcks_reg;
  logic [2:0] armed_reg; // flags seen as 1 by a status read
  logic wave_reg;
  logic wave_next;
  logic irq_reg;
  // bus state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic rd_hit;
  logic wr_status;
  logic rd_status;
  logic [7:0] wbyte;
  logic [7:0] status_rd;
  logic [7:0] trig_rd;
  logic [7:0] rd_byte;
  logic [2:0] flags_now;
  logic [2:0] flags_set;
  logic [2:0] flags_clr;
  logic [2:0] flags_next;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == tmv_pkg::OFS_COUNT) || (a == tmv_pkg::OFS_CMP_A) || (a == tmv_pkg::OFS_CMP_B) ||
                (a == tmv_pkg::OFS_MAIN_CTRL) || (a == tmv_pkg::OFS_STATUS_OUT) || (a == tmv_pkg::OFS_TRIG_CTRL);
  endfunction : known_ofs

  function automatic logic [1:0] resp_for(input logic hit);
    resp_for = hit ? tmv_pkg::RESP_OKAY : tmv_pkg::RESP_SLVERR;
  endfunction : resp_for

  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_fire = s_axi_arvalid & ~rvalid_reg;
  assign wr_hit = known_ofs(awaddr_reg);
  assign rd_hit = known_ofs(s_axi_araddr);
  assign wbyte = wdata_reg[7:0];
  assign wr_status = wr_fire & wstrb0_reg & (awaddr_reg == tmv_pkg::OFS_STATUS_OUT);
  assign rd_status = rd_fire & (s_axi_araddr == tmv_pkg::OFS_STATUS_OUT);
  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  // reserved bits read as one
  assign status_rd = tmv_pkg::STATUS_RSVD_ONES | {flag_b_reg, flag_a_reg, wrap_flag_reg, 1'b0, act_b_reg, act_a_reg};
  assign trig_rd = tmv_pkg::TRIG_RSVD_ONES | {3'h0, edge_reg, gate_reg, 1'b0, xcks_reg};
  assign rd_byte = (s_axi_araddr == tmv_pkg::OFS_COUNT) ? ctl.count :
                   (s_axi_araddr == tmv_pkg::OFS_CMP_A) ? cmp_a_reg :
                   (s_axi_araddr == tmv_pkg::OFS_CMP_B) ? cmp_b_reg :
                   (s_axi_araddr == tmv_pkg::OFS_MAIN_CTRL) ? main_ctrl_reg :
                   (s_axi_araddr == tmv_pkg::OFS_STATUS_OUT) ? status_rd :
                   (s_axi_araddr == tmv_pkg::OFS_TRIG_CTRL) ? trig_rd : 8'h00;
  // ---------------------------------------------------------------
  // flag set/clear
  // ---------------------------------------------------------------
  assign flags_now = {flag_b_reg, flag_a_reg, wrap_flag_reg};
  assign flags_set = {ctl.match_b, ctl.match_a, ctl.wrap};
  // clear needs prior read of 1
  assign flags_clr = {3{wr_status}} & armed_reg & ~{wbyte[tmv_pkg::POS_FLAG_B], wbyte[tmv_pkg::POS_FLAG_A],
                     wbyte[tmv_pkg::POS_WRAP]};
  assign flags_next = flags_set | (flags_now & ~flags_clr);
  // ---------------------------------------------------------------
  // waveform action
  // ---------------------------------------------------------------
  logic [1:0] act_a_eff;
  logic [1:0] act_b_eff;
  logic any_toggle;
  logic any_high;
  logic any_low;
  assign act_a_eff = ctl.match_a ? act_a_reg : tmv_pkg::ACT_KEEP;
  assign act_b_eff = ctl.match_b ? act_b_reg : tmv_pkg::ACT_KEEP;
  assign any_toggle = (act_a_eff == tmv_pkg::ACT_TOGGLE) || (act_b_eff == tmv_pkg::ACT_TOGGLE);
  assign any_high = (act_a_eff == tmv_pkg::ACT_HIGH) || (act_b_eff == tmv_pkg::ACT_HIGH);
  assign any_low = (act_a_eff == tmv_pkg::ACT_LOW) || (act_b_eff == tmv_pkg::ACT_LOW);
  assign wave_next = any_toggle ? ~wave_reg : any_high ? 1'b1 : any_low ? 1'b0 : wave_reg;
  // ---------------------------------------------------------------
  // control to core
  // ---------------------------------------------------------------
  assign ctl.clk_sel_lo2 = main_ctrl_reg[tmv_pkg::POS_CKS +: 2];
  assign ctl.clk_sel_hi = main_ctrl_reg[tmv_pkg::POS_CKS + 2];
  assign ctl.clr_sel = main_ctrl_reg[tmv_pkg::POS_CLR +: 2];
  assign ctl.edge_sel = edge_reg;
  assign ctl.gate_en = gate_reg;
  assign ctl.xcks = xcks_reg;
  assign ctl.cmp_a = cmp_a_reg;
  assign ctl.cmp_b = cmp_b_reg;
  assign ctl.cnt_wr = wr_fire & wstrb0_reg & (awaddr_reg == tmv_pkg::OFS_COUNT);
  assign ctl.cnt_wdata = wbyte;

  tmv_counter u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig_in(trigger_in_pin),
    .ext_clr_in(external_clear_pin),
    .ctl(ctl)
  );
  // ---------------------------------------------------------------
  // axi write channel capture
  // ---------------------------------------------------------------
  // address and data taken in either order, held until response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end
  // write and read responses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= tmv_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= tmv_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= resp_for(wr_hit);
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= resp_for(rd_hit);
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // only byte lane 0 carries register data; upper lanes are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_ctrl_reg <= tmv_pkg::RST_CTRL;
      cmp_a_reg <= tmv_pkg::RST_CMP;
      cmp_b_reg <= tmv_pkg::RST_CMP;
      act_b_reg <= tmv_pkg::ACT_KEEP;
      act_a_reg <= tmv_pkg::ACT_KEEP;
      edge_reg <= tmv_pkg::EDGE_OFF;
      gate_reg <= 1'b0;
      xcks_reg <= 1'b0;
    end
    else if (wr_fire && wstrb0_reg)
    begin
      if (awaddr_reg == tmv_pkg::OFS_MAIN_CTRL)
        main_ctrl_reg <= wbyte;
      if (awaddr_reg == tmv_pkg::OFS_CMP_A)
        cmp_a_reg <= wbyte;
      if (awaddr_reg == tmv_pkg::OFS_CMP_B)
        cmp_b_reg <= wbyte;
      if (awaddr_reg == tmv_pkg::OFS_STATUS_OUT)
      begin
        act_b_reg <= wbyte[tmv_pkg::POS_ACT_B +: 2];
        act_a_reg <= wbyte[tmv_pkg::POS_ACT_A +: 2];
      end
      if (awaddr_reg == tmv_pkg::OFS_TRIG_CTRL)
      begin
        edge_reg <= wbyte[tmv_pkg::POS_EDGE +: 2];
        gate_reg <= wbyte[tmv_pkg::POS_GATE];
        xcks_reg <= wbyte[tmv_pkg::POS_XCKS];
      end
    end
  end
  // ---------------------------------------------------------------
  // flags, read arming, waveform and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {flag_b_reg, flag_a_reg, wrap_flag_reg} <= 3'h0;
      armed_reg <= 3'h0;
      wave_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      {flag_b_reg, flag_a_reg, wrap_flag_reg} <= flags_next;
      // arm on a read of 1
      if (rd_status)
        armed_reg <= flags_now;
      else if (wr_status)
        armed_reg <= 3'h0;
      wave_reg <= wave_next;
      irq_reg <= |(flags_next & {main_ctrl_reg[tmv_pkg::POS_IE_B], main_ctrl_reg[tmv_pkg::POS_IE_A],
                                 main_ctrl_reg[tmv_pkg::POS_IE_WRAP]});
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign waveform_out_pin = wave_reg;
  assign irq = irq_reg;
endmodule : tmv_top
`default_nettype wire

// file: tb/tmv_partner.sv
// Purpose: trigger source model for the timer trigger pin
// Assumes: one aclk domain
// Notes: level changes only just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module tmv_partner (
  input wire logic aclk, // system clock
  input wire logic lvl, // wanted trigger level
  output logic trig // trigger pin
);
  always_ff @(posedge aclk)
  begin
    trig <= lvl;
  end
endmodule : tmv_partner
`default_nettype wire

// file: tb/tmv_checker.sv
// Purpose: port checks of register bus and pins
// Assumes: aclk domain, sync active-low reset
// Notes: bound onto tmv_top
`timescale 1ns/1ns
`default_nettype none
module tmv_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, // read handshakes
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // write handshakes
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, s_axi_bready, // response handshake
  input wire logic waveform_out_pin, irq // pins
);
  logic [7:0] ra; // address of read in flight
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // keep address until read data shows
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      ra <= s_axi_araddr;
    end
  end
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_stat_rsvd: assert property (s_axi_rvalid && ra == tmv_pkg::OFS_STATUS_OUT |-> s_axi_rdata[4])
    else $error("status bit 4 low");
  a_trig_rsvd: assert property (s_axi_rvalid && ra == tmv_pkg::OFS_TRIG_CTRL |-> s_axi_rdata[7:5] == 3'h7)
    else $error("trigger reserved low");
  a_trig_rsvd1: assert property (s_axi_rvalid && ra == tmv_pkg::OFS_TRIG_CTRL |-> s_axi_rdata[1])
    else $error("trigger bit 1 low");
  a_wave_reset: assert property ($rose(aresetn) |-> !waveform_out_pin) else $error("wave high at reset");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq) else $error("irq high at reset");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_wave: cover property ($rose(waveform_out_pin));
endmodule : tmv_checker
bind tmv_top tmv_checker tmv_checker_inst (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .waveform_out_pin, .irq);
`default_nettype wire

// file: tb/timer_status_output_trigger_tb.sv
// Purpose: self-checking bench for the timer block
// Assumes: axi4-lite master tasks, 4 ns aclk
// Notes: random data from a fixed-seed xorshift
`timescale 1ns/1ns
`default_nettype none
module timer_status_output_trigger_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, tlvl = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, trig, wave, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // addresses
  logic eclr = 1'b0; // external clear pin level
  logic [31:0] wdata = 32'h0, seed = 32'h96fa, rdata, got; // data
  logic [1:0] bresp, rresp, resp; // responses
  int n_mismatch = 0, checks_done = 0;
  always #2 aclk = ~aclk;
  tmv_top tmv_top_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_in_pin(trig), .external_clear_pin(eclr), .waveform_out_pin(wave), .irq(irq));
  tmv_partner tmv_partner_inst (.aclk, .lvl(tlvl), .trig(trig));
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bus tasks hold each channel until its ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    complete_run();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    complete_run();
  endtask : rd
  // bounded wait for a waveform level
  task automatic wt(input logic v);
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge aclk);
      if (wave === v) return;
    end
    n_mismatch++;
    complete_run();
  endtask : wt
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // writable trigger bits kept, reserved ones forced
  function automatic logic [31:0] trig_exp(input logic [31:0] d);
    return {24'h0, d[7:0] & 8'h1d | tmv_pkg::TRIG_RSVD_ONES};
  endfunction : trig_exp
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tmv_pkg::OFS_STATUS_OUT);
    chk(got, 32'h10);
    rd(tmv_pkg::OFS_TRIG_CTRL);
    chk(got, 32'he2);
    rd(tmv_pkg::OFS_COUNT);
    chk(got, 32'h0);
    chk({31'h0, wave}, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      wr(tmv_pkg::OFS_COUNT, seed);
      rd(tmv_pkg::OFS_COUNT);
      chk(got, {24'h0, seed[7:0]});
      wr(tmv_pkg::OFS_TRIG_CTRL, seed >> 8);
      rd(tmv_pkg::OFS_TRIG_CTRL);
      chk(got, trig_exp(seed >> 8));
    end
    rd(8'h18);
    chk({30'h0, resp}, {30'h0, tmv_pkg::RESP_SLVERR});
    // match a drives 1, match b drives 0
    wr(tmv_pkg::OFS_TRIG_CTRL, 32'h0);
    wr(tmv_pkg::OFS_CMP_A, 32'h05);
    wr(tmv_pkg::OFS_CMP_B, 32'h0a);
    wr(tmv_pkg::OFS_STATUS_OUT, 32'h06);
    wr(tmv_pkg::OFS_COUNT, 32'h0);
    wr(tmv_pkg::OFS_MAIN_CTRL, 32'h41);
    wt(1'b1);
    wt(1'b0);
    rd(tmv_pkg::OFS_STATUS_OUT);
    chk(got, 32'hd6);
    chk({31'h0, irq}, 32'h1);
    wr(tmv_pkg::OFS_STATUS_OUT, 32'h06);
    rd(tmv_pkg::OFS_STATUS_OUT);
    chk(got, 32'h16);
    chk({31'h0, irq}, 32'h0);
    wt(1'b1);
    wr(tmv_pkg::OFS_STATUS_OUT, 32'h06);
    rd(tmv_pkg::OFS_STATUS_OUT);
    chk(got, 32'h76);
    // gated count halts on clear, restarts on rising trigger
    wr(tmv_pkg::OFS_MAIN_CTRL, 32'h0);
    wr(tmv_pkg::OFS_CMP_A, 32'h03);
    wr(tmv_pkg::OFS_TRIG_CTRL, 32'h0c);
    wr(tmv_pkg::OFS_COUNT, 32'h0);
    wr(tmv_pkg::OFS_MAIN_CTRL, 32'h09);
    repeat (60) @(posedge aclk);
    wr(tmv_pkg::OFS_CMP_A, 32'h80);
    rd(tmv_pkg::OFS_COUNT);
    chk(got, 32'h0);
    tlvl <= 1'b1;
    repeat (60) @(posedge aclk);
    rd(tmv_pkg::OFS_COUNT);
    chk({31'h0, got == 32'h0}, 32'h0);
    // external rising edge clears, gating halts the count at zero
    wr(tmv_pkg::OFS_MAIN_CTRL, 32'h19);
    eclr <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(tmv_pkg::OFS_COUNT);
    chk(got, 32'h0);
    complete_run();
  end
endmodule : timer_status_output_trigger_tb
`default_nettype wire
